// ===== verilog/lfa_pkg.sv
// Package: encodings, operand fields, register map and carriers for the ALU ops
package lfa_pkg;

	// ----------------------------------------------------------------
	// Instruction word fields
	// ----------------------------------------------------------------
	localparam int INSTR_W = 14;
	localparam int CLASS_HI = 13;
	localparam int CLASS_LO = 12;
	localparam int NIB_HI = 11;
	localparam int NIB_LO = 8;
	localparam int DEST_BIT = 7;
	localparam int BSEL_HI = 9;
	localparam int BSEL_LO = 7;
	localparam int FADDR_HI = 6;
	localparam int LIT_HI = 7;
	localparam int NIB_CARRY = 4;

	// Class and nibble codes
	localparam logic [1:0] CLASS_BYTE = 2'h0;
	localparam logic [1:0] CLASS_BIT = 2'h1;
	localparam logic [1:0] CLASS_LIT = 2'h3;
	localparam logic [3:0] NIB_ADD_LIT = 4'he;
	localparam logic [3:0] NIB_ADD_LIT_MASK = 4'he;
	localparam logic [3:0] NIB_AND_LIT = 4'h9;
	localparam logic [3:0] NIB_ADD_FILE = 4'h7;
	localparam logic [3:0] NIB_AND_FILE = 4'h5;
	localparam logic [1:0] NIB_BIT_CLR_TOP = 2'h0;

	// File addresses of the port and timer count registers
	localparam logic [6:0] PORT_ADDR = 7'h06;
	localparam logic [6:0] TIMER_ADDR = 7'h01;

	// ----------------------------------------------------------------
	// Software register map
	// ----------------------------------------------------------------
	localparam int REG_AW = 2;
	localparam logic [1:0] REG_ACC = 2'h0;
	localparam logic [1:0] REG_FLAGS = 2'h1;
	localparam logic [1:0] REG_COUNT = 2'h2;
	localparam int FLAG_C = 0;
	localparam int FLAG_DIGIT = 1;
	localparam int FLAG_Z = 2;
	localparam logic [7:0] ACC_RESET = 8'h00;
	localparam logic [7:0] COUNT_RESET = 8'h00;

	// Decoded operation, one-hot
	typedef enum logic [5:0] {
		OP_NONE = 6'h01,
		OP_ADD_LIT = 6'h02,
		OP_AND_LIT = 6'h04,
		OP_ADD_FILE = 6'h08,
		OP_AND_FILE = 6'h10,
		OP_BIT_CLR = 6'h20
	} lfa_op_e;

	// Status flags
	typedef struct packed {
		logic z;
		logic digit_carry;
		logic c;
	} lfa_flags_s;

	localparam lfa_flags_s FLAGS_RESET = 3'h0;

	// Write-back request toward the register file
	typedef struct packed {
		logic en;
		logic [6:0] addr;
		logic [7:0] data;
	} lfa_fwr_s;

endpackage : lfa_pkg

// ===== verilog/lfa_core.sv
// Execute stage for literal and file add/and and bit-clear instructions
//
// The register offsets and the strobed register port were chosen for this implementation.
`timescale 1ns/1ps
`default_nettype none

module lfa_core
	import lfa_pkg::*;
(
	input wire logic clk,
	input wire logic rst,
	input wire logic instr_valid,
	input wire logic [INSTR_W-1:0] instr,
	input wire logic [7:0] file_rdata,
	input wire logic [7:0] port_pins,
	input wire logic prescaler_on_timer,
	input wire logic [REG_AW-1:0] reg_addr,
	input wire logic [7:0] reg_wdata,
	input wire logic reg_wr,
	input wire logic reg_rd,
	output logic [7:0] reg_rdata,
	output logic [7:0] acc,
	output lfa_flags_s flags,
	output lfa_fwr_s file_wr,
	output logic prescaler_clr,
	output logic instr_done
);

	// ----------------------------------------------------------------
	// Decode
	// ----------------------------------------------------------------
	lfa_op_e op;
	logic [1:0] cls;
	logic [3:0] nib;
	logic [6:0] faddr;
	logic [7:0] lit;
	logic [2:0] bsel;
	logic dest_file;
	logic exec;

	assign cls = instr[CLASS_HI:CLASS_LO];
	assign nib = instr[NIB_HI:NIB_LO];
	assign faddr = instr[FADDR_HI:0];
	assign lit = instr[LIT_HI:0];
	assign bsel = instr[BSEL_HI:BSEL_LO];
	assign dest_file = instr[DEST_BIT];

	// Anything outside the five handled encodings decodes to no-op
	always_comb begin
		op = OP_NONE;
		if (instr_valid) begin
			if (cls == CLASS_LIT && (nib & NIB_ADD_LIT_MASK) == NIB_ADD_LIT)
				op = OP_ADD_LIT;
			else if (cls == CLASS_LIT && nib == NIB_AND_LIT)
				op = OP_AND_LIT;
			else if (cls == CLASS_BYTE && nib == NIB_ADD_FILE)
				op = OP_ADD_FILE;
			else if (cls == CLASS_BYTE && nib == NIB_AND_FILE)
				op = OP_AND_FILE;
			else if (cls == CLASS_BIT && nib[3:2] == NIB_BIT_CLR_TOP)
				op = OP_BIT_CLR;
		end
	end

	assign exec = (op != OP_NONE);

	// ----------------------------------------------------------------
	// Datapath
	// ----------------------------------------------------------------
	logic [7:0] fsrc;
	logic [7:0] opnd;
	logic [8:0] sum;
	logic [4:0] low_sum;
	logic [7:0] next_res;
	logic [7:0] bit_mask;
	lfa_flags_s next_flags;
	logic to_acc;
	logic to_file;

	// Port reads see the pins, not the output latch
	assign fsrc = (faddr == PORT_ADDR) ? port_pins : file_rdata;

	// Literal ops take the low byte, file ops the file operand
	assign opnd = (op == OP_ADD_LIT || op == OP_AND_LIT) ? lit : fsrc;
	assign sum = {1'b0, acc} + {1'b0, opnd};
	assign low_sum = {1'b0, acc[3:0]} + {1'b0, opnd[3:0]};

	// Bit select mask, one generate loop iteration per bit position
	for (genvar i = 0; i < 8; i++) begin : g_mask
		assign bit_mask[i] = (bsel != 3'(i));
	end

	// Result and flag selection per operation
	always_comb begin
		next_res = 8'h00;
		next_flags = flags;
		to_acc = 1'b0;
		to_file = 1'b0;
		unique case (op)
			OP_ADD_LIT: begin
				next_res = sum[7:0];
				next_flags.c = sum[8];
				next_flags.digit_carry = low_sum[NIB_CARRY];
				next_flags.z = (sum[7:0] == 8'h00);
				to_acc = 1'b1;
			end
			OP_AND_LIT: begin
				next_res = acc & lit;
				next_flags.z = ((acc & lit) == 8'h00);
				to_acc = 1'b1;
			end
			OP_ADD_FILE: begin
				next_res = sum[7:0];
				next_flags.c = sum[8];
				next_flags.digit_carry = low_sum[NIB_CARRY];
				next_flags.z = (sum[7:0] == 8'h00);
				to_acc = !dest_file;
				to_file = dest_file;
			end
			OP_AND_FILE: begin
				next_res = acc & fsrc;
				next_flags.z = ((acc & fsrc) == 8'h00);
				to_acc = !dest_file;
				to_file = dest_file;
			end
			OP_BIT_CLR: begin
				next_res = fsrc & bit_mask;
				to_file = 1'b1;
			end
			OP_NONE: begin
				next_res = 8'h00;
			end
		endcase
	end

	// ----------------------------------------------------------------
	// Architectural state
	// ----------------------------------------------------------------
	// Instruction wins over a same-cycle software write, so no
	// executed result is ever lost to the bus
	always_ff @(posedge clk or posedge rst) begin
		if (rst) begin
			acc <= ACC_RESET;
		end else if (to_acc) begin
			acc <= next_res;
		end else if (!exec && reg_wr && reg_addr == REG_ACC) begin
			acc <= reg_wdata;
		end
	end

	// Flags
	always_ff @(posedge clk or posedge rst) begin
		if (rst) begin
			flags <= FLAGS_RESET;
		end else if (exec) begin
			flags <= next_flags;
		end else if (reg_wr && reg_addr == REG_FLAGS) begin
			flags <= {reg_wdata[FLAG_Z], reg_wdata[FLAG_DIGIT],
				reg_wdata[FLAG_C]};
		end
	end

	// Write-back toward the register file, one cycle pulse
	always_ff @(posedge clk or posedge rst) begin
		if (rst) begin
			file_wr <= '0;
		end else begin
			file_wr.en <= to_file;
			file_wr.addr <= faddr;
			file_wr.data <= next_res;
		end
	end

	// Timer write-back resets its prescaler when it owns it
	always_ff @(posedge clk or posedge rst) begin
		if (rst) begin
			prescaler_clr <= 1'b0;
		end else begin
			prescaler_clr <= to_file && faddr == TIMER_ADDR &&
				prescaler_on_timer;
		end
	end

	// Completion strobe; no op ever stalls or needs a second cycle
	always_ff @(posedge clk or posedge rst) begin
		if (rst) begin
			instr_done <= 1'b0;
		end else begin
			instr_done <= exec;
		end
	end

	// ----------------------------------------------------------------
	// Software registers
	// ----------------------------------------------------------------
	logic [7:0] exec_count;

	// Wrapping count of executed instructions, read only
	always_ff @(posedge clk or posedge rst) begin
		if (rst) begin
			exec_count <= COUNT_RESET;
		end else if (exec) begin
			exec_count <= exec_count + 8'h01;
		end
	end

	// Read data stand one cycle after the strobe; unmapped reads zero
	always_ff @(posedge clk or posedge rst) begin
		if (rst) begin
			reg_rdata <= 8'h00;
		end else if (reg_rd) begin
			unique case (reg_addr)
				REG_ACC: reg_rdata <= acc;
				REG_FLAGS: reg_rdata <= {5'h00, flags};
				REG_COUNT: reg_rdata <= exec_count;
				default: reg_rdata <= 8'h00;
			endcase
		end else begin
			reg_rdata <= 8'h00;
		end
	end

	// ----------------------------------------------------------------
	// Assertions
	// ----------------------------------------------------------------
	default clocking cb @(posedge clk);
	endclocking
	default disable iff (rst);

	// Independent reference sums for the checks
	logic [8:0] chk_lit_sum;
	logic [8:0] chk_file_sum;
	logic [7:0] chk_src;
	assign chk_src = (instr[6:0] == PORT_ADDR) ? port_pins : file_rdata;
	assign chk_lit_sum = 9'(acc) + 9'(instr[7:0]);
	assign chk_file_sum = 9'(acc) + 9'(chk_src);

	sequence s_issue;
		instr_valid && op != OP_NONE;
	endsequence

	sequence s_done;
		instr_done ##1 (instr_done == $past(exec));
	endsequence

	a_add_lit_result: assert property (op == OP_ADD_LIT |=>
		acc == $past(chk_lit_sum[7:0]) && flags.c == $past(chk_lit_sum[8])
		&& flags.z == (acc == 8'h00))
		else $error("add literal result or flags wrong");

	a_and_lit_flags: assert property (op == OP_AND_LIT |=>
		$stable(flags.c) && $stable(flags.digit_carry) &&
		flags.z == (acc == 8'h00)
		&& acc == ($past(acc) & $past(instr[7:0])))
		else $error("and literal touched wrong flags");

	a_add_file_carry: assert property (op == OP_ADD_FILE |=>
		flags.digit_carry ==
		(($past(acc[3:0]) + $past(chk_src[3:0])) > 5'h0f)
		&& flags.c == $past(chk_file_sum[8]))
		else $error("add file carry flags wrong");

	a_dest_file_write: assert property (
		(op == OP_ADD_FILE || op == OP_AND_FILE) && instr[7] |=>
		file_wr.en && file_wr.addr == $past(instr[6:0]) &&
		acc == $past(acc))
		else $error("file destination not honoured");

	a_dest_acc_write: assert property (
		(op == OP_ADD_FILE || op == OP_AND_FILE) && !instr[7] |=>
		!file_wr.en)
		else $error("accumulator destination wrote file");

	a_and_file_zero: assert property (op == OP_AND_FILE |=>
		$stable(flags.c) && $stable(flags.digit_carry) &&
		flags.z == (($past(acc) & $past(chk_src)) == 8'h00))
		else $error("and file flag update wrong");

	a_bit_clear: assert property (op == OP_BIT_CLR |=>
		$stable(flags) && file_wr.en && !file_wr.data[$past(instr[9:7])]
		&& (file_wr.data | (8'h01 << $past(instr[9:7])))
		== ($past(chk_src) | (8'h01 << $past(instr[9:7]))))
		else $error("bit clear result wrong");

	a_port_source: assert property (
		op == OP_ADD_FILE && !instr[7] && instr[6:0] == PORT_ADDR |=>
		acc == $past(8'(acc + port_pins)))
		else $error("port operand not taken from pins");

	a_prescaler_clear: assert property (
		(op == OP_BIT_CLR || ((op == OP_ADD_FILE || op == OP_AND_FILE) &&
		instr[7])) && instr[6:0] == TIMER_ADDR |=>
		prescaler_clr == $past(prescaler_on_timer))
		else $error("prescaler clear missing on timer write");

	a_single_cycle: assert property (s_issue |=> s_done)
		else $error("instruction did not finish in one cycle");

endmodule // lfa_core

`default_nettype wire

// ===== verif/test_literal_and_file_alu_ops.sv
// Self-checking bench for the literal and file ALU instruction block
`timescale 1ns/1ps
`default_nettype none

module test_literal_and_file_alu_ops;
	import lfa_pkg::*;

	logic clk;
	logic rst;
	logic instr_valid;
	logic [INSTR_W-1:0] instr;
	logic [7:0] file_rdata;
	logic [7:0] port_pins;
	logic prescaler_on_timer;
	logic [REG_AW-1:0] reg_addr;
	logic [7:0] reg_wdata;
	logic reg_wr;
	logic reg_rd;
	logic [7:0] reg_rdata;
	logic [7:0] acc;
	lfa_flags_s flags;
	lfa_fwr_s file_wr;
	logic prescaler_clr;
	logic instr_done;
	int bad_count;
	int comparisons;
	int n_exec;
	logic [7:0] rv;
	logic [10:0] r;
	logic [7:0] lit [3] = '{8'h15, 8'hf0, 8'heb};

	lfa_core i_lfa_core (
		.clk(clk),
		.rst(rst),
		.instr_valid(instr_valid),
		.instr(instr),
		.file_rdata(file_rdata),
		.port_pins(port_pins),
		.prescaler_on_timer(prescaler_on_timer),
		.reg_addr(reg_addr),
		.reg_wdata(reg_wdata),
		.reg_wr(reg_wr),
		.reg_rd(reg_rd),
		.reg_rdata(reg_rdata),
		.acc(acc),
		.flags(flags),
		.file_wr(file_wr),
		.prescaler_clr(prescaler_clr),
		.instr_done(instr_done)
	);

	// ----------------------------------------------------------------
	// Clock and helpers
	// ----------------------------------------------------------------
	// 20 MHz clock
	initial begin
		clk = 1'b0;
		forever #25 clk = ~clk;
	end

	// Compare and count
	task automatic chk(input logic [15:0] seen, input logic [15:0] exp);
		comparisons++;
		if (seen !== exp) begin
			bad_count++;
			$display("[ERR] %0t ns: seen %h expected %h", $time, seen, exp);
		end
	endtask

	// Reference sum: {z, digit carry, c, sum}
	function automatic logic [10:0] add_ref(input logic [7:0] a,
		input logic [7:0] b);
		logic [8:0] s;
		logic [4:0] h;
		s = {1'b0, a} + {1'b0, b};
		h = {1'b0, a[3:0]} + {1'b0, b[3:0]};
		return {s[7:0] == 8'h00, h[4], s[8], s[7:0]};
	endfunction

	// One-cycle register write
	task automatic wr(input logic [1:0] a, input logic [7:0] d);
		@(posedge clk);
		reg_wr <= 1'b1;
		reg_addr <= a;
		reg_wdata <= d;
		@(posedge clk);
		reg_wr <= 1'b0;
	endtask

	// Read data only stands in the cycle after the strobe
	task automatic rd(input logic [1:0] a, output logic [7:0] d);
		@(posedge clk);
		reg_rd <= 1'b1;
		reg_addr <= a;
		@(posedge clk);
		reg_rd <= 1'b0;
		#1;
		d = reg_rdata;
	endtask

	// Present a word; valid stays up so calls may run back to back
	task automatic issue(input logic [13:0] w, input logic [7:0] f,
		input logic [7:0] p);
		@(posedge clk);
		instr_valid <= 1'b1;
		instr <= w;
		file_rdata <= f;
		port_pins <= p;
		n_exec++;
	endtask

	// Single word, results settled on return
	task automatic exec(input logic [13:0] w, input logic [7:0] f,
		input logic [7:0] p);
		issue(w, f, p);
		@(posedge clk);
		instr_valid <= 1'b0;
		#1;
	endtask

	task automatic wrap_up;
		$display("comparisons %0d mismatches %0d", comparisons, bad_count);
		if (bad_count == 0 && comparisons > 0) begin
			$display("Result: passed");
		end else begin
			$display("Result: failed");
		end
		$finish;
	endtask

	// Watchdog, far beyond the fewer than a hundred cycles the tests need
	initial begin
		repeat (3000) @(posedge clk);
		bad_count++;
		$display("[ERR] %0t ns: run did not finish", $time);
		wrap_up();
	end

	// ----------------------------------------------------------------
	// Tests
	// ----------------------------------------------------------------
	initial begin
		rst = 1'b1;
		instr_valid = 1'b0;
		instr = '0;
		file_rdata = 8'h00;
		port_pins = 8'h00;
		prescaler_on_timer = 1'b0;
		reg_addr = '0;
		reg_wdata = 8'h00;
		reg_wr = 1'b0;
		reg_rd = 1'b0;
		bad_count = 0;
		comparisons = 0;
		n_exec = 0;
		repeat (8) @(posedge clk);
		rst <= 1'b0;
		// Reset values, read-only count, unmapped address
		rd(REG_ACC, rv);
		chk({8'h0, rv}, {8'h0, ACC_RESET});
		rd(REG_COUNT, rv);
		chk({8'h0, rv}, {8'h0, COUNT_RESET});
		wr(REG_ACC, 8'h33);
		rd(REG_ACC, rv);
		chk({8'h0, rv}, 16'h0033);
		@(posedge clk);
		#1;
		chk({8'h0, reg_rdata}, 16'h0000);
		wr(REG_COUNT, 8'h55);
		rd(REG_COUNT, rv);
		chk({8'h0, rv}, {8'h0, COUNT_RESET});
		rd(2'h3, rv);
		chk({8'h0, rv}, 16'h0000);
		$display("test registers done");
		// Literal add, both encodings of the spare bit, carries and zero
		rv = 8'h10;
		wr(REG_ACC, rv);
		foreach (lit[i]) begin
			exec({5'h1f, i[0], lit[i]}, 8'h00, 8'h00);
			r = add_ref(rv, lit[i]);
			chk({5'h0, flags, acc}, {5'h0, r});
			chk({15'h0, instr_done}, 16'h0001);
			rv = r[7:0];
		end
		// Literal and keeps carry and digit carry
		wr(REG_ACC, 8'ha3);
		exec(14'h395f, 8'h00, 8'h00);
		chk({5'h0, flags, acc}, {5'h0, 3'b011, 8'h03});
		exec(14'h3900, 8'h00, 8'h00);
		chk({5'h0, flags, acc}, {5'h0, 3'b111, 8'h00});
		$display("test literal done");
		// File add into accumulator, top file address, timer write-back
		@(posedge clk);
		prescaler_on_timer <= 1'b1;
		wr(REG_ACC, 8'h17);
		exec(14'h0701, 8'hc2, 8'h00);
		r = add_ref(8'h17, 8'hc2);
		chk({5'h0, flags, acc}, {5'h0, r});
		chk({15'h0, file_wr.en}, 16'h0000);
		chk({15'h0, prescaler_clr}, 16'h0000);
		exec(14'h077f, 8'h27, 8'h00);
		r = add_ref(8'hd9, 8'h27);
		chk({5'h0, flags, acc}, {5'h0, r});
		wr(REG_ACC, 8'h17);
		exec(14'h0781, 8'hc2, 8'h00);
		chk(file_wr, {1'b1, TIMER_ADDR, 8'hd9});
		chk({15'h0, prescaler_clr}, 16'h0001);
		chk({8'h0, acc}, 16'h0017);
		@(posedge clk);
		prescaler_on_timer <= 1'b0;
		exec(14'h0781, 8'hc2, 8'h00);
		chk({15'h0, prescaler_clr}, 16'h0000);
		$display("test file add done");
		// File and on the port takes the pin levels, not the latch
		wr(REG_FLAGS, 8'h03);
		wr(REG_ACC, 8'hf0);
		exec(14'h0586, 8'hff, 8'h3c);
		chk(file_wr, {1'b1, PORT_ADDR, 8'h30});
		chk({13'h0, flags}, 16'h0003);
		exec(14'h0506, 8'hff, 8'h0f);
		chk({5'h0, flags, acc}, {5'h0, 3'b111, 8'h00});
		$display("test file and done");
		// Bit clear for every bit position, flags left alone
		for (int b = 0; b < 8; b++) begin
			exec({4'h4, b[2:0], 7'h05}, 8'hff, 8'h00);
			chk(file_wr, {1'b1, 7'h05, ~(8'h01 << b)});
			chk({13'h0, flags}, 16'h0007);
		end
		exec({4'h4, 3'h0, PORT_ADDR}, 8'hff, 8'h5b);
		chk(file_wr, {1'b1, PORT_ADDR, 8'h5a});
		$display("test bit clear done");
		// Back to back words, then a word outside this block
		wr(REG_ACC, 8'h01);
		issue(14'h3e01, 8'h00, 8'h00);
		issue(14'h3e02, 8'h00, 8'h00);
		#1;
		chk({7'h0, instr_done, acc}, 16'h0102);
		issue(14'h3000, 8'h00, 8'h00);
		// The last word is not one of ours and must not count
		n_exec--;
		#1;
		chk({7'h0, instr_done, acc}, 16'h0104);
		@(posedge clk);
		instr_valid <= 1'b0;
		#1;
		chk({7'h0, instr_done, acc}, 16'h0004);
		// Same-cycle bus write to the accumulator loses to the word
		@(posedge clk);
		instr_valid <= 1'b1;
		instr <= 14'h3e01;
		reg_wr <= 1'b1;
		reg_addr <= REG_ACC;
		reg_wdata <= 8'h77;
		n_exec++;
		@(posedge clk);
		instr_valid <= 1'b0;
		reg_wr <= 1'b0;
		#1;
		chk({7'h0, instr_done, acc}, 16'h0105);
		rd(REG_COUNT, rv);
		chk({8'h0, rv}, {8'h0, n_exec[7:0]});
		$display("test sequence done");
		wrap_up();
	end

endmodule // test_literal_and_file_alu_ops

`default_nettype wire
